// File: shared/mii_defines.svh
// Purpose: named constants of the msi/intx interrupt request block
// Assumes: included by bare name wherever a figure is needed
// Notes:   definitions only
`ifndef MII_DEFINES_SVH
`define MII_DEFINES_SVH

// register map of the core end, byte addresses on the software port
`define MII_ADDR_CSR        8'h00
`define MII_ADDR_BASE       8'h04
`define MII_ADDR_STATUS     8'h08
`define MII_ADDR_MASK       8'h0C

// msi control/status field layout
`define MII_CSR_EN          0
`define MII_CSR_MMC_LO      1
`define MII_CSR_MME_LO      4
`define MII_CSR_ADDR64      7
`define MII_CSR_VMASK       8

// capabilities and reset values of the control/status field
`define MII_CAP_VMASK       1'h0
`define MII_CAP_ADDR64      1'h1
`define MII_MMC_REQ         3'h5
`define MII_MME_RST         3'h0
`define MII_MME_MAX         3'h5
`define MII_BASE_RST        16'h0000

// interrupt status bits
`define MII_IRQ_MSI_SENT    0
`define MII_IRQ_INTX_SENT   1
`define MII_IRQ_MSI_DROP    2
`define MII_IRQ_SYS_ERR     3

// message kinds, fixed traffic class and grant codes
`define MII_KIND_MSI        2'h0
`define MII_KIND_INTX_ASSRT 2'h1
`define MII_KIND_INTX_DEASS 2'h2
`define MII_TC_ZERO         3'h0
`define MII_VEC_ALL         3'h5
`define MII_VEC_FOUR        3'h2

`endif

// File: shared/mii_pkg.sv
// Purpose: types and shared arithmetic of the interrupt request block
// Assumes: mii_defines.svh on the include path
// Notes:   no state here
`default_nettype none
`include "mii_defines.svh"

package mii_pkg;

  // core end sequencer, one-hot
  typedef enum logic [2:0] {
    MII_CORE_IDLE = 3'h1,
    MII_CORE_SEND = 3'h2,
    MII_CORE_DONE = 3'h4
  } mii_core_e;

  // application end sequencer, one-hot
  typedef enum logic [1:0] {
    MII_APP_IDLE = 2'h1,
    MII_APP_REQ  = 2'h2
  } mii_app_e;

  // highest vector index granted by a multiple message enable code
  function automatic logic [4:0] mii_vec_top(input logic [2:0] mme);
    logic [2:0] lim;
    lim = (mme > `MII_MME_MAX) ? `MII_MME_MAX : mme;
    mii_vec_top = 5'((6'h01 << lim) - 6'h01);
  endfunction

  // highest vector left to the application after event vectors
  function automatic logic [4:0] mii_app_top(input logic [2:0] mme, input logic share);
    logic [4:0] top;
    top = mii_vec_top(mme);
    if (mme == `MII_VEC_FOUR && share) begin
      mii_app_top = top - 5'h01;
    end else if (mme >= `MII_VEC_FOUR) begin
      mii_app_top = top - 5'h02;
    end else begin
      mii_app_top = top;
    end
  endfunction

endpackage

`default_nettype wire

// File: shared/mii_if.sv
// Purpose: link between the core end and the application end
// Assumes: both ends on sys_clk
// Notes:   no clocking block; testbench joins the ends here
`timescale 1ns/100ps
`default_nettype none

interface mii_if;
  logic        msi_req;             // app asks for an msi
  logic        msi_ack;             // core accepted it, one cycle
  logic [2:0]  msi_traffic_class;   // tc of the app msi
  logic [4:0]  msi_vector;          // offset from base message data
  logic [4:0]  pm_vector;           // offset for hot plug / pm msi
  logic        int_status;          // level application interrupt
  logic [15:0] msi_control_status;  // msi control/status field

  modport core (input msi_req, msi_traffic_class, msi_vector, pm_vector, int_status,
                output msi_ack, msi_control_status);
  modport app  (output msi_req, msi_traffic_class, msi_vector, pm_vector, int_status,
                input msi_ack, msi_control_status);
endinterface

`default_nettype wire

// File: hdl/mii_core.sv
// Purpose: core end of the msi/intx interrupt request path
// Assumes: app holds request and fields stable until acknowledge
// Notes:   one message outstanding at a time on the message port
// How it works
// - application raises request to get an msi
// - core pulses acknowledge once request accepted
// - 3-bit traffic class taken with each msi
// - offset added to base message data
// - bit 8 reports per-vector masking capability
// - bit 7 reports 64-bit address capability
// - bits 6:4 hold granted count, power of two
// - bits 3:1 advertise requested vector count
// - no msi while enable bit clear
// - separate offset for pm / hot plug msi
// - level status makes intx, kept internally
// - at most 32 vectors
// - application uses only allocated vectors
// - acknowledge at least one cycle after request
// - all 32: 31 error, 30 pm; here pm takes user_pm_vector, or vector 31 when share_event_vector is set
// - four: split or shared top vectors
// - error and pm msi use tc0
// - completion msi may reuse transfer tc
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "mii_defines.svh"

module mii_core (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // link to the application end
  mii_if.core              lnk,
  // system events
  input  wire logic        sys_err_event,
  input  wire logic        pm_event,
  // outgoing message port
  output logic             msg_valid,
  input  wire logic        msg_ready,
  output logic [15:0]      msg_data,
  output logic [2:0]       msg_tc,
  output logic [1:0]       msg_kind,
  // software register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // interrupt
  output logic             irq
);

  // whole state of the core end
  typedef struct packed {
    mii_pkg::mii_core_e st;          // sequencer
    logic [15:0]        base_data;   // base message data
    logic               msi_en;      // msi enable
    logic [2:0]         mme;         // granted vector code
    logic [3:0]         irq_status;  // sticky events
    logic [3:0]         irq_mask;    // enables onto irq
    logic               syserr_pend; // error msi owed
    logic               pm_pend;     // pm msi owed
    logic               int_sent;    // intx state last signalled
    logic               int_level;   // internal interrupt status
    logic               from_app;    // message in flight is the app msi
    logic               ack;
    logic               msg_valid;
    logic [15:0]        msg_data;
    logic [2:0]         msg_tc;
    logic [1:0]         msg_kind;
    logic               irq;
    logic [31:0]        rdata;
  } mii_core_s;

  mii_core_s r;       // registered state
  mii_core_s next_r;  // next state

  logic [15:0] csr_word;  // assembled control/status field
  logic [3:0]  irq_set;   // events of this cycle
  logic [3:0]  irq_clr;   // write-one-to-clear bits

  // control/status field as software and the app see it
  always_comb begin
    csr_word = 16'h0000;
    csr_word[`MII_CSR_VMASK] = `MII_CAP_VMASK;
    csr_word[`MII_CSR_ADDR64] = `MII_CAP_ADDR64;
    csr_word[`MII_CSR_MME_LO +: 3] = r.mme;
    csr_word[`MII_CSR_MMC_LO +: 3] = `MII_MMC_REQ;
    csr_word[`MII_CSR_EN] = r.msi_en;
  end

  // next state: register port, event capture, message sequencer
  always_comb begin
    next_r = r;
    irq_set = 4'h0;
    irq_clr = 4'h0;
    next_r.ack = 1'b0;
    next_r.rdata = 32'h0000_0000;
    next_r.int_level = lnk.int_status;
    // software writes
    if (reg_wr) begin
      unique case (reg_addr)
        `MII_ADDR_CSR: begin
          next_r.msi_en = reg_wdata[`MII_CSR_EN];
          // reserved grant codes are ignored, keeping at most 32 vectors
          if (reg_wdata[`MII_CSR_MME_LO +: 3] <= `MII_MME_MAX) begin
            next_r.mme = reg_wdata[`MII_CSR_MME_LO +: 3];
          end
        end
        `MII_ADDR_BASE: begin
          next_r.base_data = reg_wdata[15:0];
        end
        `MII_ADDR_STATUS: begin
          irq_clr = reg_wdata[3:0];
        end
        `MII_ADDR_MASK: begin
          next_r.irq_mask = reg_wdata[3:0];
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end
    // software reads, data stand one cycle later only
    if (reg_rd) begin
      unique case (reg_addr)
        `MII_ADDR_CSR:    next_r.rdata = {16'h0000, csr_word};
        `MII_ADDR_BASE:   next_r.rdata = {16'h0000, r.base_data};
        `MII_ADDR_STATUS: next_r.rdata = {28'h000_0000, r.irq_status};
        `MII_ADDR_MASK:   next_r.rdata = {28'h000_0000, r.irq_mask};
        default:          next_r.rdata = 32'h0000_0000;
      endcase
    end
    // owed event messages, a new event wins over consumption below
    if (sys_err_event) begin
      irq_set[`MII_IRQ_SYS_ERR] = 1'b1;
    end
    // sequencer
    unique case (r.st)
      mii_pkg::MII_CORE_IDLE: begin
        if (r.syserr_pend && r.msi_en) begin
          // system error on the top granted vector
          next_r.syserr_pend = 1'b0;
          next_r.from_app = 1'b0;
          next_r.msg_kind = `MII_KIND_MSI;
          next_r.msg_data = r.base_data + {11'h000, mii_pkg::mii_vec_top(r.mme)};
          next_r.msg_tc = `MII_TC_ZERO;
          next_r.msg_valid = 1'b1;
          next_r.st = mii_pkg::MII_CORE_SEND;
        end else if (r.pm_pend && r.msi_en) begin
          next_r.pm_pend = 1'b0;
          next_r.from_app = 1'b0;
          next_r.msg_kind = `MII_KIND_MSI;
          next_r.msg_data = r.base_data
                          + {11'h000, lnk.pm_vector & mii_pkg::mii_vec_top(r.mme)};
          next_r.msg_tc = `MII_TC_ZERO;
          next_r.msg_valid = 1'b1;
          next_r.st = mii_pkg::MII_CORE_SEND;
        end else if (lnk.msi_req && r.msi_en) begin
          // request seen now, acknowledge comes two cycles later at least
          next_r.from_app = 1'b1;
          next_r.msg_kind = `MII_KIND_MSI;
          next_r.msg_data = r.base_data
                          + {11'h000, lnk.msi_vector & mii_pkg::mii_vec_top(r.mme)};
          next_r.msg_tc = lnk.msi_traffic_class;
          next_r.msg_valid = 1'b1;
          next_r.st = mii_pkg::MII_CORE_SEND;
        end else if (lnk.msi_req) begin
          // disabled: accept and drop so the app never hangs
          irq_set[`MII_IRQ_MSI_DROP] = 1'b1;
          next_r.ack = 1'b1;
          next_r.st = mii_pkg::MII_CORE_DONE;
        end else if (!r.msi_en && (r.int_level != r.int_sent)) begin
          // intx only while msi is off; always on tc0
          next_r.from_app = 1'b0;
          next_r.int_sent = r.int_level;
          next_r.msg_kind = r.int_level ? `MII_KIND_INTX_ASSRT : `MII_KIND_INTX_DEASS;
          next_r.msg_data = 16'h0000;
          next_r.msg_tc = `MII_TC_ZERO;
          next_r.msg_valid = 1'b1;
          next_r.st = mii_pkg::MII_CORE_SEND;
        end
        // events owed while msi is off are discarded
        if (!r.msi_en) begin
          next_r.syserr_pend = 1'b0;
          next_r.pm_pend = 1'b0;
        end
      end
      mii_pkg::MII_CORE_SEND: begin
        if (msg_ready) begin
          next_r.msg_valid = 1'b0;
          if (r.msg_kind == `MII_KIND_MSI) begin
            irq_set[`MII_IRQ_MSI_SENT] = 1'b1;
          end else begin
            irq_set[`MII_IRQ_INTX_SENT] = 1'b1;
          end
          next_r.ack = r.from_app;
          next_r.st = mii_pkg::MII_CORE_DONE;
        end
      end
      mii_pkg::MII_CORE_DONE: begin
        // one idle cycle lets the app drop its request
        next_r.st = mii_pkg::MII_CORE_IDLE;
      end
    endcase
    if (sys_err_event) begin
      next_r.syserr_pend = 1'b1;
    end
    if (pm_event) begin
      next_r.pm_pend = 1'b1;
    end
    // sticky status: set wins over clear
    next_r.irq_status = (r.irq_status & ~irq_clr) | irq_set;
    next_r.irq = |(next_r.irq_status & next_r.irq_mask);
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '{st: mii_pkg::MII_CORE_IDLE, base_data: `MII_BASE_RST, mme: `MII_MME_RST,
             default: '0};
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flops
  assign lnk.msi_ack = r.ack;
  assign lnk.msi_control_status = csr_word;
  assign msg_valid = r.msg_valid;
  assign msg_data = r.msg_data;
  assign msg_tc = r.msg_tc;
  assign msg_kind = r.msg_kind;
  assign reg_rdata = r.rdata;
  assign irq = r.irq;

endmodule

`default_nettype wire

// File: hdl/mii_app.sv
// Purpose: application end of the msi/intx interrupt request path
// Assumes: user side is logic on sys_clk
// Notes:   one msi at a time; user waits while busy is high
`timescale 1ns/100ps
`default_nettype none
`include "mii_defines.svh"

module mii_app (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // link to the core end
  mii_if.app               lnk,
  // user requests
  input  wire logic        user_msi_go,
  input  wire logic [4:0]  user_vector,
  input  wire logic [2:0]  user_tc,
  input  wire logic [4:0]  user_pm_vector,
  input  wire logic        user_int_level,
  input  wire logic        share_event_vector,
  // user status
  output logic             user_busy,
  output logic             user_done
);

  // whole state of the application end
  typedef struct packed {
    mii_pkg::mii_app_e st;      // sequencer
    logic              req;     // msi request to the core
    logic [2:0]        tc;      // held traffic class
    logic [4:0]        vec;     // held vector offset
    logic [4:0]        pm_vec;  // offset for pm / hot plug
    logic              int_lvl; // level interrupt to the core
    logic              done;    // one-cycle completion
  } mii_app_s;

  mii_app_s r;       // registered state
  mii_app_s next_r;  // next state

  logic [2:0] granted;  // granted vector code from the core
  logic [4:0] app_top;  // highest vector the app may use

  // allocation seen in the control/status field
  always_comb begin
    granted = lnk.msi_control_status[`MII_CSR_MME_LO +: 3];
    app_top = mii_pkg::mii_app_top(granted, share_event_vector);
  end

  // next state
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.int_lvl = user_int_level;
    next_r.pm_vec = share_event_vector ? mii_pkg::mii_vec_top(granted)
                                       : user_pm_vector;
    unique case (r.st)
      mii_pkg::MII_APP_IDLE: begin
        if (user_msi_go) begin
          next_r.req = 1'b1;
          // tc is the caller's, e.g. that of the data transfer
          next_r.tc = user_tc;
          // clamp into the granted, non-reserved range
          next_r.vec = (user_vector > app_top) ? app_top : user_vector;
          next_r.st = mii_pkg::MII_APP_REQ;
        end
      end
      mii_pkg::MII_APP_REQ: begin
        // fields stay frozen until the acknowledge
        if (lnk.msi_ack) begin
          next_r.req = 1'b0;
          next_r.done = 1'b1;
          next_r.st = mii_pkg::MII_APP_IDLE;
        end
      end
    endcase
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '{st: mii_pkg::MII_APP_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flops
  assign lnk.msi_req = r.req;
  assign lnk.msi_traffic_class = r.tc;
  assign lnk.msi_vector = r.vec;
  assign lnk.pm_vector = r.pm_vec;
  assign lnk.int_status = r.int_lvl;
  assign user_busy = r.req;
  assign user_done = r.done;

endmodule

`default_nettype wire

// File: bench/mii_properties.sv
// Purpose: link checks between the core end and the app end
// Assumes: one clock domain, sync active high reset
// Notes:   sees only the interface signals
`timescale 1ns/100ps
`default_nettype none
`include "mii_defines.svh"

module mii_properties (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // link signals
  input wire logic        msi_req,
  input wire logic        msi_ack,
  input wire logic [2:0]  msi_traffic_class,
  input wire logic [4:0]  msi_vector,
  input wire logic [15:0] msi_control_status
);
  // granted code and highest vector the app may raise
  logic [2:0] gnt;
  logic [5:0] vtop;
  assign gnt  = msi_control_status[6:4];
  // share option allows one more vector at grant four, so bound loosely
  assign vtop = (gnt >= 3'h3) ? (6'h01 << gnt) - 6'h03 :
                (gnt == 3'h2) ? 6'h02 : (6'h01 << gnt) - 6'h01;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_ack_has_req: assert property (msi_ack |-> msi_req)
    else $error("ack seen without a request");
  chk_ack_not_first: assert property ($rose(msi_req) |-> !msi_ack)
    else $error("ack in the request cycle");
  chk_ack_one_cycle: assert property (msi_ack |=> !msi_ack)
    else $error("ack longer than one cycle");
  chk_req_drops: assert property (msi_ack |=> !msi_req)
    else $error("request kept after ack");
  chk_req_held: assert property (msi_req && !msi_ack |=> msi_req
    && $stable(msi_traffic_class) && $stable(msi_vector))
    else $error("request or fields moved before ack");
  chk_csr_caps: assert property (msi_control_status[15:7] ==
    {7'h00, `MII_CAP_VMASK, `MII_CAP_ADDR64})
    else $error("capability bits wrong");
  chk_csr_request: assert property (msi_control_status[3:1] == `MII_MMC_REQ)
    else $error("requested count wrong");
  chk_grant_legal: assert property (gnt <= 3'h5)
    else $error("grant code reserved");
  chk_vec_allowed: assert property (msi_req |-> {1'b0, msi_vector} <= vtop)
    else $error("vector outside the allocation");
endmodule

`default_nettype wire

// File: bench/tb_top.sv
// Purpose: joins both ends and checks messages, registers and irq
// Assumes: fixed seed, 100 MHz sys_clk
// Notes:   expectations from bench functions only
`timescale 1ns/100ps
`default_nettype none
`include "mii_defines.svh"

module tb_top;
  // clock, reset and core inputs
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        sys_err_event = 1'b0;
  logic        pm_event = 1'b0;
  logic        msg_ready = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  // app inputs
  logic        user_msi_go = 1'b0;
  logic [4:0]  user_vector = 5'h00;
  logic [2:0]  user_tc = 3'h0;
  logic [4:0]  user_pm_vector = 5'h00;
  logic        user_int_level = 1'b0;
  logic        share_event_vector = 1'b0;
  // outputs
  logic        msg_valid;
  logic [15:0] msg_data;
  logic [2:0]  msg_tc;
  logic [1:0]  msg_kind;
  logic [31:0] reg_rdata;
  logic        irq;
  logic        user_busy;
  logic        user_done;
  // bookkeeping
  int          mismatches = 0;
  int          num_checks = 0;
  int          vcnt = 0;
  integer      seed = 10122;

  always #5 sys_clk = ~sys_clk;
  // cycles with a message offered, to prove none is sent
  always @(posedge sys_clk) if (msg_valid === 1'b1) vcnt <= vcnt + 1;

  mii_if lnk ();
  mii_core u_mii_core (.sys_clk(sys_clk), .rst(rst), .lnk(lnk),
    .sys_err_event(sys_err_event), .pm_event(pm_event), .msg_valid(msg_valid),
    .msg_ready(msg_ready), .msg_data(msg_data), .msg_tc(msg_tc), .msg_kind(msg_kind),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  mii_app u_mii_app (.sys_clk(sys_clk), .rst(rst), .lnk(lnk), .user_msi_go(user_msi_go),
    .user_vector(user_vector), .user_tc(user_tc), .user_pm_vector(user_pm_vector),
    .user_int_level(user_int_level), .share_event_vector(share_event_vector),
    .user_busy(user_busy), .user_done(user_done));
  mii_properties u_mii_properties (.sys_clk(sys_clk), .rst(rst), .msi_req(lnk.msi_req),
    .msi_ack(lnk.msi_ack), .msi_traffic_class(lnk.msi_traffic_class),
    .msi_vector(lnk.msi_vector), .msi_control_status(lnk.msi_control_status));

  // highest app vector for a grant code and share option
  function automatic logic [4:0] top_of(input logic [2:0] g, input logic s);
    logic [5:0] t;
    t = (6'h01 << g) - 6'h01;
    if (g == 3'h2 && s) t = t - 6'h01;
    else if (g >= 3'h2) t = t - 6'h02;
    top_of = t[4:0];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one-cycle strobes, data read in the cycle after
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic app_msi(input logic [4:0] v, input logic [2:0] tc, input logic s);
    @(posedge sys_clk);
    user_msi_go <= 1'b1;
    user_vector <= v;
    user_tc <= tc;
    share_event_vector <= s;
    @(posedge sys_clk);
    user_msi_go <= 1'b0;
    #1;
  endtask

  task automatic ev_pulse(input logic se);
    @(posedge sys_clk);
    sys_err_event <= se;
    pm_event <= !se;
    @(posedge sys_clk);
    sys_err_event <= 1'b0;
    pm_event <= 1'b0;
    #1;
  endtask

  // waits for a message, stalls at random, then takes it
  task automatic wait_msg(input logic [15:0] d, input logic [2:0] tc, input logic [1:0] k);
    int n;
    n = 0;
    while (msg_valid !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    repeat ($unsigned($random(seed)) % 4) @(posedge sys_clk);
    #1;
    check({15'h0000, msg_valid, msg_data}, {16'h0001, d});
    check({27'h0000000, msg_kind, msg_tc}, {27'h0000000, k, tc});
    @(posedge sys_clk);
    msg_ready <= 1'b1;
    @(posedge sys_clk);
    msg_ready <= 1'b0;
    #1;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (user_done !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(32'(n < 60), 32'h00000001);
  endtask

  // watchdog, well past the expected run
  initial begin
    #300000;
    mismatches++;
    print_verdict();
  end

  initial begin
    logic [31:0] rd;
    logic [15:0] base;
    logic [4:0]  v;
    logic [4:0]  ev;
    logic [2:0]  tc;
    logic        s;
    int          g;
    int          j;
    int          c0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    reg_read(8'h00, rd);
    // no vector masking, 64-bit capable, 32 requested, grant 1, msi off
    check(rd, 32'h0000008A);
    reg_read(8'h08, rd);
    check(rd, 32'h00000000);
    reg_read(8'h10, rd);
    check(rd, 32'h00000000);
    check(32'(irq), 32'h00000000);
    $display("test reset done");
    // request while disabled: acked, dropped, flagged, irq raised and cleared
    reg_write(8'h0C, 32'h00000004);
    c0 = vcnt;
    app_msi(5'h00, 3'h0, 1'b0);
    wait_done();
    check(32'(vcnt), 32'(c0));
    reg_read(8'h08, rd);
    check(rd, 32'h00000004);
    check(32'(irq), 32'h00000001);
    reg_write(8'h08, 32'h00000004);
    repeat (2) @(posedge sys_clk);
    #1;
    check(32'(irq), 32'h00000000);
    reg_write(8'h0C, 32'h00000000);
    $display("test disabled done");
    // every grant code with random vectors and classes
    base = 16'($random(seed));
    reg_write(8'h04, {16'h0000, base});
    for (g = 0; g < 6; g++) begin
      reg_write(8'h00, 32'h00000001 | 32'(g << 4));
      reg_read(8'h00, rd);
      check(rd, 32'h0000008B | 32'(g << 4));
      for (j = 0; j < 4; j++) begin
        v = (j == 0) ? 5'h1F : 5'($random(seed));
        tc = 3'($random(seed));
        s = 1'($random(seed));
        ev = (v > top_of(3'(g), s)) ? top_of(3'(g), s) : v;
        app_msi(v, tc, s);
        check(32'(user_busy), 32'h00000001);
        wait_msg(base + 16'(ev), tc, 2'h0);
        wait_done();
        check(32'(user_busy), 32'h00000000);
      end
    end
    reg_write(8'h00, 32'h00000061);
    reg_read(8'h00, rd);
    check(32'(rd[6:4]), 32'h00000005);
    $display("test msi done");
    // system and pm events, split then shared top vector
    reg_write(8'h08, 32'h0000000F);
    share_event_vector <= 1'b0;
    user_pm_vector <= 5'h1E;
    ev_pulse(1'b1);
    wait_msg(base + 16'h001F, 3'h0, 2'h0);
    ev_pulse(1'b0);
    wait_msg(base + 16'h001E, 3'h0, 2'h0);
    share_event_vector <= 1'b1;
    reg_write(8'h00, 32'h00000021);
    ev_pulse(1'b0);
    wait_msg(base + 16'h0003, 3'h0, 2'h0);
    ev_pulse(1'b1);
    wait_msg(base + 16'h0003, 3'h0, 2'h0);
    reg_read(8'h08, rd);
    check(32'(rd[3]), 32'h00000001);
    check(32'(irq), 32'h00000000);
    $display("test events done");
    // level status becomes intx assert then deassert
    reg_write(8'h00, 32'h00000000);
    user_int_level <= 1'b1;
    wait_msg(16'h0000, 3'h0, 2'h1);
    user_int_level <= 1'b0;
    wait_msg(16'h0000, 3'h0, 2'h2);
    reg_read(8'h08, rd);
    check(32'(rd[1]), 32'h00000001);
    $display("test intx done");
    print_verdict();
  end
endmodule

`default_nettype wire
